/* File: verilog/rmos_sequencer.sv */
/*
 Run and motion output sequencer with an AXI4-Lite register slave.
 Assumes contact inputs and type switches are asynchronous, the length
 logic inputs share SYS_CLK, and the run contact is latched externally.
*/
// The address map and register access over AXI4-Lite were left to the implementer.
// Functional notes
// - Run starts only with job ready, no error and all conditions met.
// - Halt, controller error or emergency stop drop automatic run.
// - Open safety interlock forces the machine out of run.
// - Automatic run starts and stops from the external run contact.
// - Emergency stop or overload halts the line.
// - Automatic shear or press firing only while in run, or while coasting on coast-fire types.
// - Feed-to-stop types accept manual press only in halt.
// - Non-stop types accept manual crop while running.
// - Machine type code from switches chooses the sequencing.
// - Material movement is counted even during emergency stop.
// - Forward-controlled motion: forward and run outputs work independently.
// - Delay after cut drops forward after each cut; run stays on in forward-controlled motion only.
// - Some types keep firing on targets while the line coasts.
// - Run-controlled motion: run output drops at once on any halt.
// - Two-speed types follow the selected forward-slow or fast-slow scheme.
// - Single-speed types always use forward-slow.
// - Forward-slow: forward in runs and jog forward; reverse in jog reverse.
// - Forward-slow: slow off only in run fast; run only while running.
// - Fast-slow: fast only in run fast; slow in run slow and jogs.
// - Fast-slow: reverse in jog reverse, run while running, all off in halt.
`timescale 1ns/1ps
`include "rmos_defs.svh"

module rmos_sequencer #(
    parameter int STILL_CYCLES = `RMOS_STILL_MS * (`RMOS_CLK_HZ / 1000)
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire rmos_pkg::rmos_pin_in_type PIN_IN,
    input wire logic [3:0] TYPE_SW,
    input wire rmos_pkg::rmos_len_in_type LEN_IN,
    output rmos_pkg::rmos_pin_out_type PIN_OUT,
    output logic [2:0] STATE_OUT,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import rmos_pkg::*;

    typedef struct packed {
        rmos_pin_in_type s1;
        rmos_pin_in_type s2;
        logic cnt_d;
        logic [3:0] type1;
        logic [3:0] type2;
        rmos_state_type state;
        logic coast;
        logic [21:0] still_cnt;
        logic dac_hold;
        logic [15:0] dac_cnt;
        logic crop_d;
        logic press_d;
        rmos_pin_out_type pins;
        logic [4:0] ctrl;
        logic [15:0] dac_cycles;
        logic [31:0] position;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rmos_reg_type;

    localparam logic [21:0] STILL_LAST = 22'(STILL_CYCLES - 1);

    rmos_reg_type r_reg;
    rmos_reg_type r_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        logic stop_cond;
        logic running;
        logic feed_to_stop;
        logic two_speed;
        logic fast_slow;
        logic lms_run;
        logic cnt_edge;
        logic crop_edge;
        logic press_edge;
        logic auto_ok;
        logic [31:0] ctrl_word;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        r_next = r_reg;
        stop_cond = 1'b0;
        running = 1'b0;
        feed_to_stop = 1'b0;
        two_speed = 1'b0;
        fast_slow = 1'b0;
        lms_run = 1'b0;
        cnt_edge = 1'b0;
        crop_edge = 1'b0;
        press_edge = 1'b0;
        auto_ok = 1'b0;
        ctrl_word = 32'h0;
        waddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'h0;

        // ----------------------------------------------------------------
        // Input synchronisers
        // ----------------------------------------------------------------
        r_next.s1 = PIN_IN;
        r_next.s2 = r_reg.s1;
        r_next.type1 = TYPE_SW;
        r_next.type2 = r_reg.type1;
        r_next.cnt_d = r_reg.s2.count_in;
        r_next.crop_d = r_reg.s2.manual_crop_in;
        r_next.press_d = r_reg.s2.manual_press_in;
        cnt_edge = r_reg.s2.count_in & ~r_reg.cnt_d;
        crop_edge = r_reg.s2.manual_crop_in & ~r_reg.crop_d;
        press_edge = r_reg.s2.manual_press_in & ~r_reg.press_d;

        feed_to_stop = r_reg.type2[`RMOS_TYPE_FEED_TO_STOP];
        two_speed = r_reg.type2[`RMOS_TYPE_TWO_SPEED];
        fast_slow = two_speed & r_reg.ctrl[`RMOS_CTRL_FAST_SLOW];
        lms_run = r_reg.ctrl[`RMOS_CTRL_LMS_RUN];

        // ----------------------------------------------------------------
        // Material position
        // ----------------------------------------------------------------
        // count always
        if (cnt_edge) begin
            if (r_reg.s2.dir_in) begin
                r_next.position = r_reg.position - 32'h1;
            end else begin
                r_next.position = r_reg.position + 32'h1;
            end
        end

        // ----------------------------------------------------------------
        // Machine state
        // ----------------------------------------------------------------
        // stop causes
        stop_cond = r_reg.s2.halt_in | r_reg.ctrl[`RMOS_CTRL_ERR] | r_reg.s2.estop_in | ~r_reg.s2.interlock_in
            | r_reg.s2.overload_in;
        case (r_reg.state)
            ST_HALT: begin
                if (r_reg.s2.run_in && r_reg.ctrl[`RMOS_CTRL_JOB] && !stop_cond) begin
                    r_next.state = LEN_IN.slow_zone ? ST_RUN_SLOW : ST_RUN_FAST;
                end else if (!stop_cond && r_reg.s2.jog_fwd_in && !r_reg.s2.jog_rev_in) begin
                    r_next.state = ST_JOG_FWD;
                end else if (!stop_cond && r_reg.s2.jog_rev_in && !r_reg.s2.jog_fwd_in) begin
                    r_next.state = ST_JOG_REV;
                end
            end
            ST_RUN_FAST, ST_RUN_SLOW: begin
                if (stop_cond || !r_reg.s2.run_in) begin
                    r_next.state = ST_HALT;
                end else begin
                    r_next.state = LEN_IN.slow_zone ? ST_RUN_SLOW : ST_RUN_FAST;
                end
            end
            ST_JOG_FWD: begin
                if (stop_cond || !r_reg.s2.jog_fwd_in || r_reg.s2.jog_rev_in) begin
                    r_next.state = ST_HALT;
                end
            end
            ST_JOG_REV: begin
                if (stop_cond || !r_reg.s2.jog_rev_in || r_reg.s2.jog_fwd_in) begin
                    r_next.state = ST_HALT;
                end
            end
            default: begin
                r_next.state = ST_HALT;
            end
        endcase
        running = (r_next.state == ST_RUN_FAST) || (r_next.state == ST_RUN_SLOW);

        if (running) begin
            r_next.coast = 1'b0;
        end else if ((r_reg.state == ST_RUN_FAST || r_reg.state == ST_RUN_SLOW)
            && r_reg.type2[`RMOS_TYPE_COAST_FIRE]) begin
            r_next.coast = 1'b1;
            r_next.still_cnt = 22'h0;
        end else if (r_reg.coast) begin
            if (cnt_edge) begin
                r_next.still_cnt = 22'h0;
            end else if (r_reg.still_cnt >= STILL_LAST) begin
                r_next.coast = 1'b0;
            end else begin
                r_next.still_cnt = r_reg.still_cnt + 22'h1;
            end
        end

        // ----------------------------------------------------------------
        // Firing
        // ----------------------------------------------------------------
        // auto firing
        auto_ok = running || r_next.coast;
        r_next.pins.shear_fire = auto_ok & LEN_IN.shear_target;
        r_next.pins.press_fire = auto_ok & LEN_IN.press_target;
        if (crop_edge && (!feed_to_stop || r_next.state == ST_HALT)) begin
            r_next.pins.shear_fire = 1'b1;
        end
        if (press_edge && (!feed_to_stop || r_next.state == ST_HALT)) begin
            r_next.pins.press_fire = 1'b1;
        end

        if (!running) begin
            r_next.dac_hold = 1'b0;
        end else if (r_reg.ctrl[`RMOS_CTRL_DAC_EN] && r_next.pins.shear_fire) begin
            r_next.dac_hold = 1'b1;
            r_next.dac_cnt = r_reg.dac_cycles;
        end else if (r_reg.dac_hold) begin
            if (r_reg.dac_cnt == 16'h0) begin
                r_next.dac_hold = 1'b0;
            end else begin
                r_next.dac_cnt = r_reg.dac_cnt - 16'h1;
            end
        end

        // ----------------------------------------------------------------
        // Motion outputs
        // ----------------------------------------------------------------
        r_next.pins.reverse = (r_next.state == ST_JOG_REV);
        if (fast_slow) begin
            r_next.pins.forward = 1'b0;
            r_next.pins.fast = (r_next.state == ST_RUN_FAST) && !r_next.dac_hold;
            r_next.pins.slow = ((r_next.state == ST_RUN_SLOW) && !r_next.dac_hold) || (r_next.state == ST_JOG_FWD)
                || (r_next.state == ST_JOG_REV);
        end else begin
            r_next.pins.forward = ((running && !r_next.dac_hold) || (r_next.state == ST_JOG_FWD));
            r_next.pins.fast = 1'b0;
            r_next.pins.slow = (r_next.state != ST_RUN_FAST);
        end
        r_next.pins.run_hold_relay = lms_run ? (running && !r_next.dac_hold) : running;

        // ----------------------------------------------------------------
        // Register bus
        // ----------------------------------------------------------------
        if (S_AXI_AWVALID && !r_reg.aw_got && !r_reg.bvalid) begin
            r_next.aw_got = 1'b1;
            r_next.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !r_reg.w_got && !r_reg.bvalid) begin
            r_next.w_got = 1'b1;
            r_next.w_data = S_AXI_WDATA;
            r_next.w_strb = S_AXI_WSTRB;
        end
        if (r_reg.aw_got && r_reg.w_got) begin
            waddr = r_reg.aw_addr;
            wdata = r_reg.w_data;
            wstrb = r_reg.w_strb;
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = `RMOS_RESP_OKAY;
            if (waddr == `RMOS_OFS_CTRL) begin
                ctrl_word = merge({27'h0, r_reg.ctrl}, wdata, wstrb);
                r_next.ctrl = ctrl_word[4:0];
            end else if (waddr == `RMOS_OFS_DAC) begin
                ctrl_word = merge({16'h0, r_reg.dac_cycles}, wdata, wstrb);
                r_next.dac_cycles = ctrl_word[15:0];
            end else if (waddr == `RMOS_OFS_STATUS || waddr == `RMOS_OFS_POSITION) begin
                r_next.bresp = `RMOS_RESP_OKAY;
            end else begin
                r_next.bresp = `RMOS_RESP_SLVERR;
            end
        end else if (r_reg.bvalid && S_AXI_BREADY) begin
            r_next.bvalid = 1'b0;
        end

        if (S_AXI_ARVALID && !r_reg.rvalid) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = `RMOS_RESP_OKAY;
            if (S_AXI_ARADDR == `RMOS_OFS_CTRL) begin
                r_next.rdata = {27'h0, r_reg.ctrl};
            end else if (S_AXI_ARADDR == `RMOS_OFS_DAC) begin
                r_next.rdata = {16'h0, r_reg.dac_cycles};
            end else if (S_AXI_ARADDR == `RMOS_OFS_STATUS) begin
                r_next.rdata = {12'h0, r_reg.type2, 3'h0, r_reg.coast, r_reg.dac_hold, r_reg.pins, 1'b0,
                    r_reg.state};
            end else if (S_AXI_ARADDR == `RMOS_OFS_POSITION) begin
                r_next.rdata = r_reg.position;
            end else begin
                r_next.rdata = 32'h0;
                r_next.rresp = `RMOS_RESP_SLVERR;
            end
        end else if (r_reg.rvalid && S_AXI_RREADY) begin
            r_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            r_reg <= '0;
            r_reg.state <= ST_HALT;
            r_reg.ctrl <= `RMOS_CTRL_RESET;
            r_reg.dac_cycles <= `RMOS_DAC_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // Port drive
    // ----------------------------------------------------------------
    assign PIN_OUT = r_reg.pins;
    assign STATE_OUT = r_reg.state;
    assign S_AXI_AWREADY = !r_reg.aw_got && !r_reg.bvalid;
    assign S_AXI_WREADY = !r_reg.w_got && !r_reg.bvalid;
    assign S_AXI_BVALID = r_reg.bvalid;
    assign S_AXI_BRESP = r_reg.bresp;
    assign S_AXI_ARREADY = !r_reg.rvalid;
    assign S_AXI_RVALID = r_reg.rvalid;
    assign S_AXI_RDATA = r_reg.rdata;
    assign S_AXI_RRESP = r_reg.rresp;

endmodule

/* File: verilog/rmos_defs.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 run and motion output sequencer.
 Assumes a 25 MHz system clock and a 32-bit register bus with byte addresses.
*/
`ifndef RMOS_DEFS_SVH
`define RMOS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RMOS_OFS_CTRL 8'h00
`define RMOS_OFS_DAC 8'h04
`define RMOS_OFS_STATUS 8'h08
`define RMOS_OFS_POSITION 8'h0c

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define RMOS_CTRL_JOB 0
`define RMOS_CTRL_ERR 1
`define RMOS_CTRL_LMS_RUN 2
`define RMOS_CTRL_FAST_SLOW 3
`define RMOS_CTRL_DAC_EN 4
`define RMOS_CTRL_RESET 5'h00
`define RMOS_DAC_RESET 16'h0000

// ----------------------------------------------------------------
// Machine type code fields
// ----------------------------------------------------------------
`define RMOS_TYPE_FEED_TO_STOP 0
`define RMOS_TYPE_TWO_SPEED 1
`define RMOS_TYPE_COAST_FIRE 2

// ----------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------
`define RMOS_RESP_OKAY 2'h0
`define RMOS_RESP_SLVERR 2'h2
`define RMOS_CLK_HZ 25000000
`define RMOS_STILL_MS 100

`endif

/* File: verilog/rmos_pkg.sv */
/*
 Types shared by the run and motion output sequencer and its bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rmos_pkg;

    typedef enum logic [2:0] {
        ST_HALT,
        ST_RUN_FAST,
        ST_RUN_SLOW,
        ST_JOG_FWD,
        ST_JOG_REV
    } rmos_state_type;

    // Contact inputs from machine wiring; 1 means the contact is closed.
    typedef struct packed {
        logic run_in;
        logic halt_in;
        logic estop_in;
        logic interlock_in;
        logic overload_in;
        logic jog_fwd_in;
        logic jog_rev_in;
        logic manual_crop_in;
        logic manual_press_in;
        logic count_in;
        logic dir_in;
    } rmos_pin_in_type;

    // Requests from the length logic, on the same clock.
    typedef struct packed {
        logic slow_zone;
        logic shear_target;
        logic press_target;
    } rmos_len_in_type;

    typedef struct packed {
        logic run_hold_relay;
        logic forward;
        logic fast;
        logic slow;
        logic reverse;
        logic shear_fire;
        logic press_fire;
    } rmos_pin_out_type;

endpackage

/* File: verif/rmos_machine_model.sv */
/*
 Machine wiring model around the sequencer: the run request relay.
 Assumes the run hold relay output of the sequencer and a momentary run button.
*/
`timescale 1ns/1ps
module rmos_machine_model (
    input wire logic clk,
    input wire logic run_button,
    input wire logic run_hold_relay,
    output logic run_request_relay = 1'h0
);
    // hold contact latches around the button
    always @(posedge clk) begin
        run_request_relay <= run_button | run_hold_relay;
    end
endmodule

/* File: verif/rmos_sequencer_props.sv */
/*
 Concurrent checks on the sequencer machine-side ports.
 Assumes the single SYS_CLK domain and synchronous active-high RST.
*/
`timescale 1ns/1ps
module rmos_sequencer_props (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire rmos_pkg::rmos_pin_in_type PIN_IN,
    input wire rmos_pkg::rmos_pin_out_type PIN_OUT,
    input wire logic [2:0] STATE_OUT
);
    import rmos_pkg::*;
    logic run_s;
    assign run_s = (STATE_OUT == 3'h1) || (STATE_OUT == 3'h2);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    property p_state_legal; STATE_OUT <= 3'h4; endproperty
    a_state_legal: assert property (p_state_legal) else $error("illegal state code");
    property p_jog_entry; (STATE_OUT inside {3'h3, 3'h4}) && !($past(STATE_OUT) inside {3'h3, 3'h4}) |->
        $past(STATE_OUT) == 3'h0; endproperty
    a_jog_entry: assert property (p_jog_entry) else $error("jog entered from run");
    property p_run_start; run_s && $past(STATE_OUT) == 3'h0 |-> $past(PIN_IN.run_in, 3) &&
        $past(PIN_IN.interlock_in, 3) && !$past(PIN_IN.estop_in, 3); endproperty
    a_run_start: assert property (p_run_start) else $error("run began without its conditions");
    property p_estop; PIN_IN.estop_in [*4] |=> !run_s && !PIN_OUT.run_hold_relay; endproperty
    a_estop: assert property (p_estop) else $error("run kept during emergency stop");
    property p_interlock; !PIN_IN.interlock_in [*4] |=> !run_s; endproperty
    a_interlock: assert property (p_interlock) else $error("run kept with interlock open");
    property p_overload; PIN_IN.overload_in [*4] |=> !run_s; endproperty
    a_overload: assert property (p_overload) else $error("run kept during overload");
    property p_halt_in; PIN_IN.halt_in [*4] |=> !run_s; endproperty
    a_halt_in: assert property (p_halt_in) else $error("run kept during halt request");
    property p_reverse; PIN_OUT.reverse == (STATE_OUT == 3'h4); endproperty
    a_reverse: assert property (p_reverse) else $error("reverse output outside jog reverse");
    property p_run_out; PIN_OUT.run_hold_relay |-> run_s; endproperty
    a_run_out: assert property (p_run_out) else $error("run output outside run states");
    property p_fast; PIN_OUT.fast |-> STATE_OUT == 3'h1; endproperty
    a_fast: assert property (p_fast) else $error("fast output outside run fast");
    property p_halt_fwd; STATE_OUT inside {3'h0, 3'h4} |-> !PIN_OUT.forward && !PIN_OUT.fast; endproperty
    a_halt_fwd: assert property (p_halt_fwd) else $error("motion output on in halt or jog reverse");
    property p_slow; (STATE_OUT == 3'h1 |-> !PIN_OUT.slow) and (STATE_OUT > 3'h2 |-> PIN_OUT.slow); endproperty
    a_slow: assert property (p_slow) else $error("slow output wrong for state");
endmodule

bind rmos_sequencer rmos_sequencer_props u_props (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT),
    .STATE_OUT(STATE_OUT)
);

/* File: verif/tb_top.sv */
/*
 Self-checking bench for the sequencer: register bus tasks and machine scenarios.
 Assumes the machine wiring model and the bound port checker.
*/
`timescale 1ns/1ps
`include "rmos_defs.svh"
module tb_top;
    import rmos_pkg::*;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    rmos_pin_in_type pin = 11'h080;
    rmos_pin_in_type pin_w;
    rmos_len_in_type len = 3'h0;
    rmos_pin_out_type pout;
    logic [3:0] type_sw = 4'h0;
    logic [2:0] st;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, btn = 1'h0;
    logic run_w, awready, wready, bvalid, arready, rvalid;
    logic fwd_off = 1'h0, run_lost = 1'h0;
    logic [1:0] bresp, rresp;
    logic [4:0] tbl [2][5] = '{'{5'h02, 5'h18, 5'h1a, 5'h0a, 5'h03}, '{5'h00, 5'h14, 5'h12, 5'h02, 5'h03}};
    int miscompares = 0;
    int cmp_count = 0;

    always #20 sys_clk = ~sys_clk;
    always_comb begin
        pin_w = pin;
        pin_w.run_in = run_w;
    end

    rmos_machine_model u_machine (.clk(sys_clk), .run_button(btn), .run_hold_relay(pout.run_hold_relay),
        .run_request_relay(run_w));
    rmos_sequencer #(.STILL_CYCLES(20)) DUT (.SYS_CLK(sys_clk), .RST(rst), .PIN_IN(pin_w), .TYPE_SW(type_sw),
        .LEN_IN(len), .PIN_OUT(pout), .STATE_OUT(st), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic guard(input logic ok);
        if (ok !== 1'h1) begin
            miscompares++;
            $display("mismatch at %0t: bus answer timed out", $time);
            finish_test();
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 60);
        guard(bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, `RMOS_RESP_OKAY}, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string msg);
        int n = 0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 60);
        guard(rvalid);
        rready <= 1'h0;
        chk({30'h0, rresp}, {30'h0, er}, msg);
        chk(rdata, ed, msg);
    endtask
    task automatic mot(input logic [2:0] es, input logic [4:0] eo, input string msg);
        wt(6);
        chk({29'h0, st}, {29'h0, es}, msg);
        chk({27'h0, pout.run_hold_relay, pout.forward, pout.fast, pout.slow, pout.reverse}, {27'h0, eo}, msg);
    endtask
    task automatic start(input logic [2:0] es, input logic [4:0] eo, input string msg);
        btn <= 1'h1;
        mot(es, eo, msg);
        btn <= 1'h0;
    endtask
    // Kind 0 is a target, 1 a manual press, 2 a manual crop.
    task automatic try(input int k, input logic e, input string msg);
        logic s = 1'h0;
        case (k)
            0: len.shear_target <= 1'h1;
            1: pin.manual_press_in <= 1'h1;
            default: pin.manual_crop_in <= 1'h1;
        endcase
        repeat (8) begin
            @(posedge sys_clk);
            s = s | ((k == 1) ? pout.press_fire : pout.shear_fire);
        end
        len.shear_target <= 1'h0;
        pin.manual_press_in <= 1'h0;
        pin.manual_crop_in <= 1'h0;
        wt(3);
        chk({31'h0, s}, {31'h0, e}, msg);
    endtask
    task automatic visit(input int sc);
        mot(3'h0, tbl[sc][0], "halt");
        pin.jog_fwd_in <= 1'h1;
        mot(3'h3, tbl[sc][3], "jog fwd");
        pin.jog_fwd_in <= 1'h0;
        mot(3'h0, tbl[sc][0], "jog end");
        pin.jog_rev_in <= 1'h1;
        mot(3'h4, tbl[sc][4], "jog rev");
        pin.jog_rev_in <= 1'h0;
        start(3'h1, tbl[sc][1], "run fast");
        mot(3'h1, tbl[sc][1], "latched");
        pin.jog_fwd_in <= 1'h1;
        mot(3'h1, tbl[sc][1], "jog in run");
        pin.jog_fwd_in <= 1'h0;
        len.slow_zone <= 1'h1;
        mot(3'h2, tbl[sc][2], "run slow");
        len.slow_zone <= 1'h0;
        try(0, 1'h1, "auto fire");
        try(2, 1'h1, "crop in run");
        pin.halt_in <= 1'h1;
        mot(3'h0, tbl[sc][0], "halted");
        pin.halt_in <= 1'h0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        mot(3'h0, 5'h02, "reset state");
        rd(`RMOS_OFS_CTRL, 32'h0, `RMOS_RESP_OKAY, "ctrl reset");
        rd(8'h40, 32'h0, `RMOS_RESP_SLVERR, "unmapped");
        start(3'h0, 5'h02, "no job");
        wr(`RMOS_OFS_CTRL, 32'h3);
        start(3'h0, 5'h02, "error set");
        try(0, 1'h0, "fire in halt");
        for (int sc = 0; sc < 3; sc++) begin
            type_sw <= (sc == 1) ? 4'h2 : 4'h0;
            wr(`RMOS_OFS_CTRL, (sc > 0) ? 32'h9 : 32'h1);
            visit((sc == 1) ? 1 : 0);
        end
        for (int i = 0; i < 3; i++) begin
            start(3'h1, 5'h18, "restart");
            case (i)
                0: pin.estop_in <= 1'h1;
                1: pin.interlock_in <= 1'h0;
                default: pin.overload_in <= 1'h1;
            endcase
            mot(3'h0, 5'h02, "stop cause");
            if (i == 0) begin
                repeat (3) begin
                    pin.count_in <= 1'h1;
                    wt(2);
                    pin.count_in <= 1'h0;
                    wt(2);
                end
                rd(`RMOS_OFS_POSITION, 32'h3, `RMOS_RESP_OKAY, "count in stop");
                pin.dir_in <= 1'h1;
                pin.count_in <= 1'h1;
                wt(3);
                rd(`RMOS_OFS_POSITION, 32'h2, `RMOS_RESP_OKAY, "count down");
            end
            pin.estop_in <= 1'h0;
            pin.interlock_in <= 1'h1;
            pin.overload_in <= 1'h0;
        end
        type_sw <= 4'h1;
        start(3'h1, 5'h18, "stop type run");
        try(1, 1'h0, "press in run");
        pin.halt_in <= 1'h1;
        mot(3'h0, 5'h02, "stop type halt");
        pin.halt_in <= 1'h0;
        try(1, 1'h1, "press in halt");
        type_sw <= 4'h0;
        wr(`RMOS_OFS_DAC, 32'h3);
        rd(`RMOS_OFS_DAC, 32'h3, `RMOS_RESP_OKAY, "dac readback");
        wr(`RMOS_OFS_CTRL, 32'h11);
        start(3'h1, 5'h18, "cut hold run");
        len.shear_target <= 1'h1;
        wt(1);
        len.shear_target <= 1'h0;
        repeat (10) begin
            @(posedge sys_clk);
            fwd_off = fwd_off | !pout.forward;
            run_lost = run_lost | !pout.run_hold_relay;
        end
        chk({31'h0, fwd_off}, 32'h1, "forward dropped");
        chk({31'h0, run_lost}, 32'h0, "run kept");
        type_sw <= 4'h4;
        wr(`RMOS_OFS_CTRL, 32'h5);
        pin.halt_in <= 1'h1;
        mot(3'h0, 5'h02, "run mode halt");
        try(0, 1'h1, "coast fire");
        wt(20);
        try(0, 1'h0, "coast over");
        finish_test();
    end
endmodule
